// [bench/tb.sv]
// Self-checking testbench for the USB device status and info block
`timescale 1ns/10ps
module tb import uds_pkg::*;;
    localparam int DEB = 20; // Shortened debounce
    localparam int IDL = 30; // Shortened idle threshold
    logic ref_clk, rstn, regWr, regRd, busPower, busActivity, busReset;
    logic pullupEn, suspendOut, devDefault, irq;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rdVal;
    logic [6:0] devAddr;
    uds_sof_t sofIn;
    uds_err_rep_t errIn;
    int errTotal = 0, numChecks = 0, cycles = 0;
    uds_host_model host (.ref_clk(ref_clk), .busPower(busPower),
        .busActivity(busActivity), .busReset(busReset), .sofIn(sofIn),
        .errIn(errIn));
    uds_status_info #(.DEBOUNCE_CYCLES(DEB), .IDLE_CYCLES(IDL)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .busPower(busPower), .busActivity(busActivity),
        .busReset(busReset), .sofIn(sofIn), .errIn(errIn),
        .pullupEn(pullupEn), .suspendOut(suspendOut),
        .devDefault(devDefault), .devAddr(devAddr), .irq(irq));
    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the two hundred or so cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errTotal = errTotal + 1;
            giveVerdict();
        end
    end
    task automatic giveVerdict();
        $display("Checks made %0d, mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : giveVerdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time,
                     what, got, exp);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    // Read, then compare the masked answer in the cycle it stands
    task automatic rdf(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp, input string what);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdata;
        chk(rdVal & m, exp, what);
    endtask : rdf
    task automatic testPower();
        host.setPower(1'b1);
        wr(ADDR_CMDSTAT, 32'h0001_0000);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, pullupEn}, 32'h1, "pull-up on");
        rdf(ADDR_CMDSTAT, 32'h1000_0000, 32'h1000_0000, "power bit");
        host.setPower(1'b0);
        repeat (DEB - 3) @(posedge ref_clk);
        host.setPower(1'b1);
        chk({31'h0, pullupEn}, 32'h1, "glitch ignored");
        host.setPower(1'b0);
        repeat (DEB + 4) @(posedge ref_clk);
        chk({31'h0, pullupEn}, 32'h0, "pull-up off");
        rdf(ADDR_CMDSTAT, 32'h0100_0000, 32'h0100_0000, "conn chg");
        wr(ADDR_CMDSTAT, 32'h0001_0000);
        rdf(ADDR_CMDSTAT, 32'h0100_0000, 32'h0100_0000, "zero kept");
        wr(ADDR_CMDSTAT, 32'h0101_0000);
        rdf(ADDR_CMDSTAT, 32'h0100_0000, 32'h0, "conn chg clr");
        host.setPower(1'b1);
        @(posedge ref_clk);
        #1;
        chk({31'h0, pullupEn}, 32'h1, "fast rise");
    endtask : testPower
    task automatic testSuspend();
        wr(ADDR_CMDSTAT, 32'h0201_0000);
        host.pulse(1'b1, 1'b0, '0, '0);
        repeat (IDL + 6) @(posedge ref_clk);
        chk({31'h0, suspendOut}, 32'h1, "suspended");
        rdf(ADDR_CMDSTAT, 32'h0202_0000, 32'h0202_0000, "susp chg");
        wr(ADDR_CMDSTAT, 32'h0201_0000);
        host.pulse(1'b1, 1'b0, '0, '0);
        #1;
        chk({31'h0, suspendOut}, 32'h0, "resumed");
        rdf(ADDR_CMDSTAT, 32'h0200_0000, 32'h0200_0000, "resume chg");
    endtask : testSuspend
    task automatic testReset();
        wr(ADDR_IRQMASK, 32'h0000_0004);
        wr(ADDR_IRQSTAT, 32'h0000_000f);
        host.pulse(1'b0, 1'b1, '0, '0);
        rdf(ADDR_CMDSTAT, 32'h0400_0000, 32'h0400_0000, "rst chg");
        chk({24'h0, devDefault, devAddr}, 32'h80, "default");
        chk({31'h0, irq}, 32'h1, "irq up");
        wr(ADDR_IRQMASK, 32'h0);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(ADDR_IRQMASK, 32'h0000_0004);
        wr(ADDR_IRQSTAT, 32'h0000_0004);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(ADDR_CMDSTAT, 32'h0401_0000);
        rdf(ADDR_CMDSTAT, 32'h0400_0000, 32'h0, "rst chg clr");
        rdf(8'h10, 32'hffff_ffff, 32'h0, "unmapped");
    endtask : testReset
    task automatic testInfo();
        host.pulse(1'b0, 1'b0, {1'b1, 1'b0, 11'h5a3}, '0);
        rdf(ADDR_INFO, 32'h07ff, 32'h05a3, "frame");
        repeat (5) @(posedge ref_clk);
        rdf(ADDR_INFO, 32'h07ff, 32'h05a3, "frame kept");
        host.pulse(1'b0, 1'b0, {1'b1, 1'b1, 11'h7ff}, '0);
        rdf(ADDR_INFO, 32'h07ff, 32'h07ff, "bad crc frame");
        for (int c = 1; c < 8; c++) begin
            host.pulse(1'b0, 1'b0, '0, {1'b1, c[3:0]});
            rdf(ADDR_INFO, 32'h7800, 32'(c << 11), "err");
        end
        wr(ADDR_INFO, 32'h0);
        rdf(ADDR_INFO, 32'hffff_ffff, 32'h07ff, "err write");
    endtask : testInfo
    // Main sequence: reset held six cycles, then each scenario
    initial begin
        rstn = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        rdf(ADDR_CMDSTAT, 32'hffff_ffff, 32'h0, "cmdstat reset");
        testPower();
        testSuspend();
        testReset();
        testInfo();
        giveVerdict();
    end
endmodule : tb

// [bench/uds_host_model.sv]
// Host-side model: bus power, upstream activity, bus reset, SOF, errors
`timescale 1ns/10ps
module uds_host_model
    import uds_pkg::*;
(
    input wire logic ref_clk,
    output logic busPower,
    output logic busActivity,
    output logic busReset,
    output uds_sof_t sofIn,
    output uds_err_rep_t errIn
);
    // Quiet, unpowered bus at time zero
    initial begin
        busPower = 1'b0;
        busActivity = 1'b0;
        busReset = 1'b0;
        sofIn = '0;
        errIn = '0;
    end
    // Switch bus power just after an edge
    task automatic setPower(input logic v);
        @(posedge ref_clk);
        busPower <= v;
    endtask : setPower
    // One-cycle event; released data lines show inverted junk, not old data
    task automatic pulse(input logic act, input logic rst, input uds_sof_t s,
                         input uds_err_rep_t e);
        @(posedge ref_clk);
        busActivity <= act;
        busReset <= rst;
        sofIn <= s;
        errIn <= e;
        @(posedge ref_clk);
        busActivity <= 1'b0;
        busReset <= 1'b0;
        sofIn <= {2'b00, ~s.frame};
        errIn <= {1'b0, ~e.code};
    endtask : pulse
endmodule : uds_host_model

// [bench/uds_status_info_sva.sv]
// Checker for the USB device status and info block
`timescale 1ns/10ps
module uds_status_info_sva
    import uds_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 20,
    parameter int IDLE_CYCLES = 30
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic busPower,
    input wire logic busActivity,
    input wire logic busReset,
    input wire uds_sof_t sofIn,
    input wire uds_err_rep_t errIn,
    input wire logic pullupEn,
    input wire logic suspendOut,
    input wire logic devDefault,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Helper counters: low power run and idle run with pull-up on
    // ------------------------------------------------------------
    logic [31:0] lowCnt_r, lowCnt_nxt, idleCnt_r, idleCnt_nxt;
    // Next counts; any activity, reset or detach restarts idle
    always_comb begin
        lowCnt_nxt = busPower ? 32'h0 : lowCnt_r + 32'h1;
        idleCnt_nxt = idleCnt_r + 32'h1;
        if (busActivity || busReset || !pullupEn) begin
            idleCnt_nxt = 32'h0;
        end
    end
    // Register the counts
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_r <= 32'h0;
            idleCnt_r <= 32'h0;
        end else begin
            lowCnt_r <= lowCnt_nxt;
            idleCnt_r <= idleCnt_nxt;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Slack of one cycle: the filter and pull-up share one register stage
    AST_NO_DROP_WITH_POWER: assert property (
        busPower && !regWr |=> !$fell(pullupEn))
        else $error("pull-up dropped while bus power present");
    // The low run must cover the whole debounce time
    AST_DEBOUNCE: assert property (
        $fell(pullupEn) && !$past(regWr) |-> lowCnt_r >= DEBOUNCE_CYCLES)
        else $error("pull-up dropped before debounce time");
    AST_PULLUP_NEEDS_POWER: assert property (
        regRd && regAddr == ADDR_CMDSTAT && pullupEn
        |=> regRdata[POS_BUSPWR])
        else $error("pull-up on without filtered power");
    AST_RESET_DEFAULT: assert property (
        busReset |=> devDefault && !suspendOut)
        else $error("bus reset did not restore default state");
    AST_ACTIVITY_WAKES: assert property (
        busActivity |=> !suspendOut)
        else $error("suspend held through activity");
    // Suspend needs more idle cycles than the threshold
    AST_IDLE_BEFORE_SUSPEND: assert property (
        $rose(suspendOut) |-> idleCnt_r >= IDLE_CYCLES + 1)
        else $error("suspend entered too early");
    AST_READ_IDLE_ZERO: assert property (
        !regRd |=> regRdata == 32'h0)
        else $error("read data not zero outside read answer");
    AST_SOF_FRAME: assert property (
        sofIn.valid ##2 (regRd && regAddr == ADDR_INFO)
        |=> regRdata[10:0] == $past(sofIn.frame, 3))
        else $error("frame number not loaded from last SOF");
    AST_ERR_CODE: assert property (
        errIn.valid ##2 (regRd && regAddr == ADDR_INFO)
        |=> regRdata[14:11] == $past(errIn.code, 3))
        else $error("error code not the latest one");
    AST_RESET_FLAG: assert property (
        busReset ##2 (regRd && regAddr == ADDR_CMDSTAT)
        |=> regRdata[POS_RST_CHG])
        else $error("reset change flag not set");
    // Main scenarios reached
    cover property ($rose(suspendOut));
    cover property ($fell(pullupEn));
    cover property ($rose(irq));
endmodule : uds_status_info_sva

bind uds_status_info uds_status_info_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .IDLE_CYCLES(IDLE_CYCLES)) chk (.ref_clk(ref_clk), .rstn(rstn),
    .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .busPower(busPower), .busActivity(busActivity), .busReset(busReset),
    .sofIn(sofIn), .errIn(errIn), .pullupEn(pullupEn),
    .suspendOut(suspendOut), .devDefault(devDefault), .irq(irq));

// [design/uds_pkg.sv]
// Package for the USB device status and info block
package uds_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CMDSTAT = 8'h00; // Command/status
    localparam logic [7:0] ADDR_INFO = 8'h04;    // Frame and error info
    localparam logic [7:0] ADDR_IRQSTAT = 8'h08; // Sticky event status
    localparam logic [7:0] ADDR_IRQMASK = 8'h0c; // Event mask

    // ------------------------------------------------------------
    // Command/status field positions
    // ------------------------------------------------------------
    localparam int POS_ATTACH = 16;     // attach_request, R/W
    localparam int POS_SUSPEND = 17;    // suspend_state, RO
    localparam int POS_CONN_CHG = 24;   // connect_change_flag
    localparam int POS_SUSP_CHG = 25;   // suspend_change_flag
    localparam int POS_RST_CHG = 26;    // bus_reset_change_flag
    localparam int POS_BUSPWR = 28;     // bus_power_filtered

    // ------------------------------------------------------------
    // Info field positions
    // ------------------------------------------------------------
    localparam int POS_FRAME_LO = 0;    // last_frame_number 10:0
    localparam int POS_ERR_LO = 11;     // error code 14:11

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_CONN = 0;        // Connect change event
    localparam int IRQ_SUSP = 1;        // Suspend change event
    localparam int IRQ_RST = 2;         // Bus reset event
    localparam int IRQ_ERR = 3;         // New error event
    localparam int IRQ_W = 4;           // Number of events

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [10:0] FRAME_RST = 11'h000;
    localparam logic [3:0] ERR_RST = 4'h0;
    localparam logic [6:0] ADDR_DEFAULT = 7'h00; // Default USB address

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;               // ref_clk rate
    localparam int DEBOUNCE_US = 3000;          // 3 ms power debounce
    localparam int IDLE_US = 3000;              // 3 ms suspend idle
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int IDLE_CYC = IDLE_US * CLK_MHZ;

    // Error codes
    typedef enum logic [3:0] {
        UDS_ERR_NONE = 4'h0,
        UDS_ERR_PID_ENC = 4'h1,
        UDS_ERR_PID_UNK = 4'h2,
        UDS_ERR_UNEXP = 4'h3,
        UDS_ERR_TOK_CRC = 4'h4,
        UDS_ERR_DAT_CRC = 4'h5,
        UDS_ERR_TIMEOUT = 4'h6,
        UDS_ERR_BABBLE = 4'h7
    } uds_err_t;

    // Received start-of-frame packet
    typedef struct packed {
        logic valid;          // One-cycle strobe: SOF received
        logic crcBad;         // SOF failed CRC, frame still loaded
        logic [10:0] frame;   // Frame number as received
    } uds_sof_t;

    // Error report from the packet engine
    typedef struct packed {
        logic valid;          // One-cycle strobe: error seen
        logic [3:0] code;     // Error code
    } uds_err_rep_t;

endpackage : uds_pkg

// [design/uds_status_info.sv]
// USB device status flags, bus-power debounce and info register
`timescale 1ns/10ps

module uds_status_info
    import uds_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC, // Shorten in simulation
    parameter int IDLE_CYCLES = IDLE_CYC          // Shorten in simulation
) (
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Bus-side inputs
    input wire logic busPower,
    input wire logic busActivity,
    input wire logic busReset,
    input wire uds_sof_t sofIn,
    input wire uds_err_rep_t errIn,
    // Outputs
    output logic pullupEn,
    output logic suspendOut,
    output logic devDefault,
    output logic [6:0] devAddr,
    output logic irq
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Write hit on a given register address
    // One function keeps all four write decodes identical
    function automatic logic wrHit(input logic [7:0] a, input logic [7:0] t,
                                   input logic w);
        wrHit = w && (a == t);
    endfunction : wrHit

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic attach_r, attach_nxt;           // Software attach request
    logic busPwrF_r, busPwrF_nxt;         // Filtered bus power
    // Counters are 32 bits so the full debounce fits at any clock
    logic [31:0] lowCnt_r, lowCnt_nxt;    // Time bus power stayed low
    logic suspend_r, suspend_nxt;         // Suspend state
    logic [31:0] idleCnt_r, idleCnt_nxt;  // Idle time on upstream port
    logic connChg_r, connChg_nxt;         // Connect change flag
    logic suspChg_r, suspChg_nxt;         // Suspend change flag
    logic rstChg_r, rstChg_nxt;           // Bus reset change flag
    logic [10:0] frame_r, frame_nxt;      // Last frame number
    logic [3:0] err_r, err_nxt;           // Last error code
    logic [IRQ_W-1:0] irqStat_r, irqStat_nxt; // Sticky events
    logic [IRQ_W-1:0] irqMask_r, irqMask_nxt; // Event mask
    logic pullup_r, pullup_nxt;           // Pull-up drive
    logic default_r, default_nxt;         // Default-state indicator
    logic [6:0] addr_r, addr_nxt;         // Bus address, zero by default
    logic [31:0] rdata_r, rdata_nxt;      // Read data
    logic irq_r, irq_nxt;                 // Interrupt line
    logic [IRQ_W-1:0] evt;                // Events this cycle
    logic pullupDrop;                     // Pull-up lost by power loss
    logic wrCmd, wrInfo, wrStat, wrMask;  // Write decodes

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wrCmd = wrHit(regAddr, ADDR_CMDSTAT, regWr);
    assign wrInfo = wrHit(regAddr, ADDR_INFO, regWr);
    assign wrStat = wrHit(regAddr, ADDR_IRQSTAT, regWr);
    assign wrMask = wrHit(regAddr, ADDR_IRQMASK, regWr);

    // Unmapped write addresses match no decode and are dropped
    // A pull-up drop is flagged only when filtered power fell
    // Software clearing attach is not a power loss: no flag
    assign pullupDrop = pullup_r && !busPwrF_nxt;

    // ------------------------------------------------------------
    // Next state of link status
    // ------------------------------------------------------------
    always_comb begin
        // Attach is the only writable bit of command/status here
        attach_nxt = attach_r;
        if (wrCmd) begin
            attach_nxt = regWdata[POS_ATTACH];
        end
        // Power filter: rise at once, fall after debounce
        // One high sample restarts the whole debounce window
        // The count holds at its limit, so it cannot wrap
        busPwrF_nxt = busPwrF_r;
        lowCnt_nxt = lowCnt_r;
        if (busPower) begin
            busPwrF_nxt = 1'b1;
            lowCnt_nxt = 32'h0;
        end else if (lowCnt_r >= 32'(DEBOUNCE_CYCLES - 1)) begin
            busPwrF_nxt = 1'b0;
        end else begin
            lowCnt_nxt = lowCnt_r + 32'h1;
        end
        // Pull-up follows filtered power and attach request
        // Built from next values so both change on one edge
        pullup_nxt = busPwrF_nxt && attach_nxt;
        // Suspend: idle count, any activity wakes
        // Reset signalling is bus activity, never idle time
        // The idle count also holds at its limit once suspended
        suspend_nxt = suspend_r;
        idleCnt_nxt = idleCnt_r;
        if (busActivity || busReset) begin
            suspend_nxt = 1'b0;
            idleCnt_nxt = 32'h0;
        end else if (!pullup_r) begin
            // Disconnected devices are not suspended
            suspend_nxt = 1'b0;
            idleCnt_nxt = 32'h0;
        end else if (idleCnt_r >= 32'(IDLE_CYCLES)) begin
            suspend_nxt = 1'b1;
        end else begin
            idleCnt_nxt = idleCnt_r + 32'h1;
        end
        // Default state on bus reset; no logic here ever leaves it
        default_nxt = default_r;
        addr_nxt = addr_r;
        if (busReset) begin
            default_nxt = 1'b1;
            // Unconfigured device answers address zero only
            addr_nxt = ADDR_DEFAULT;
        end
    end

    // ------------------------------------------------------------
    // Events and change flags
    // ------------------------------------------------------------
    always_comb begin
        // Connect and suspend events use next values, so each is seen once; reset and error follow their input strobes
        evt = '0;
        evt[IRQ_CONN] = pullupDrop;
        evt[IRQ_SUSP] = suspend_nxt != suspend_r;
        evt[IRQ_RST] = busReset;
        evt[IRQ_ERR] = errIn.valid;
        // Set wins over a same-cycle write-one clear
        connChg_nxt = evt[IRQ_CONN] ||
            (connChg_r && !(wrCmd && regWdata[POS_CONN_CHG]));
        suspChg_nxt = evt[IRQ_SUSP] ||
            (suspChg_r && !(wrCmd && regWdata[POS_SUSP_CHG]));
        rstChg_nxt = evt[IRQ_RST] ||
            (rstChg_r && !(wrCmd && regWdata[POS_RST_CHG]));
        // Status keeps its own copy, so masking hides no event
        irqStat_nxt = evt |
            (irqStat_r & ~(wrStat ? regWdata[IRQ_W-1:0] : '0));
        irqMask_nxt = wrMask ? regWdata[IRQ_W-1:0] : irqMask_r;
        // Next values here save a cycle of interrupt latency
        irq_nxt = |(irqStat_nxt & irqMask_nxt);
    end

    // ------------------------------------------------------------
    // Info register next values
    // ------------------------------------------------------------
    always_comb begin
        // The frame field is read-only: writes never reach it
        // Frame only moves on a received SOF, good or not
        frame_nxt = frame_r;
        if (sofIn.valid) begin
            frame_nxt = sofIn.frame;
        end
        // Software may write the code; hardware error wins
        // so a fresh fault is never hidden from the next read
        err_nxt = err_r;
        if (wrInfo) begin
            err_nxt = regWdata[POS_ERR_LO+3:POS_ERR_LO];
        end
        if (errIn.valid) begin
            err_nxt = errIn.code;
        end
    end

    // ------------------------------------------------------------
    // Read mux, data valid in the cycle after the strobe
    // ------------------------------------------------------------
    // Registered, so the answer stands for exactly one cycle
    always_comb begin
        // Idle cycles return zero, keeping stale data off the bus
        // Reserved bits read as zero
        rdata_nxt = 32'h0;
        if (regRd) begin
            case (regAddr)
                // Write-one-clear flags read back their live value
                ADDR_CMDSTAT: begin
                    rdata_nxt[POS_ATTACH] = attach_r;
                    rdata_nxt[POS_SUSPEND] = suspend_r;
                    rdata_nxt[POS_CONN_CHG] = connChg_r;
                    rdata_nxt[POS_SUSP_CHG] = suspChg_r;
                    rdata_nxt[POS_RST_CHG] = rstChg_r;
                    rdata_nxt[POS_BUSPWR] = busPwrF_r;
                end
                ADDR_INFO: begin
                    rdata_nxt[POS_FRAME_LO+10:POS_FRAME_LO] = frame_r;
                    rdata_nxt[POS_ERR_LO+3:POS_ERR_LO] = err_r;
                end
                ADDR_IRQSTAT: rdata_nxt[IRQ_W-1:0] = irqStat_r;
                ADDR_IRQMASK: rdata_nxt[IRQ_W-1:0] = irqMask_r;
                // Unmapped addresses read zero
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Link status: power filter, suspend, attach and address
    // Reset state matches an unpowered, unconfigured device
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            attach_r <= 1'b0;
            busPwrF_r <= 1'b0;
            lowCnt_r <= 32'h0;
            suspend_r <= 1'b0;
            idleCnt_r <= 32'h0;
            pullup_r <= 1'b0;
            default_r <= 1'b1;
            addr_r <= ADDR_DEFAULT;
        end else begin
            attach_r <= attach_nxt;
            busPwrF_r <= busPwrF_nxt;
            lowCnt_r <= lowCnt_nxt;
            suspend_r <= suspend_nxt;
            idleCnt_r <= idleCnt_nxt;
            pullup_r <= pullup_nxt;
            default_r <= default_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Change flags, interrupt status, mask and line
    // All clear at reset so no interrupt is pending at start
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            connChg_r <= 1'b0;
            suspChg_r <= 1'b0;
            rstChg_r <= 1'b0;
            irqStat_r <= '0;
            irqMask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            connChg_r <= connChg_nxt;
            suspChg_r <= suspChg_nxt;
            rstChg_r <= rstChg_nxt;
            irqStat_r <= irqStat_nxt;
            irqMask_r <= irqMask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Info register: last frame number and error code
    // Both start from zero, meaning no frame and no error yet
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            frame_r <= FRAME_RST;
            err_r <= ERR_RST;
        end else begin
            frame_r <= frame_nxt;
            err_r <= err_nxt;
        end
    end

    // Read data register, zero outside a read answer
    // A separate stage keeps the read mux off the output pin
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    // No path from an input reaches an output pin directly
    assign regRdata = rdata_r;
    assign pullupEn = pullup_r;
    assign suspendOut = suspend_r;
    assign devDefault = default_r;
    // Address register holds zero after reset and after every bus reset
    assign devAddr = addr_r;
    assign irq = irq_r;

endmodule : uds_status_info
